// ### hdl/adsq_pkg.sv
// shared constants, types and states of the acquisition sequencer core
package adsq_pkg;
	// register indices on address lines 4..1
	localparam logic [3:0] REG_TIMER = 4'hB;
	localparam logic [3:0] REG_FIFO = 4'hC;
	localparam logic [3:0] REG_LIMIT = 4'hD;
	// fifo geometry
	localparam int FIFO_AW = 5;
	localparam logic [5:0] FIFO_FULL = 6'h20;
	// timer: 5-bit prescaler, then a two-cycle tail
	localparam logic [4:0] PRE_MAX = 5'h1F;
	localparam logic [1:0] TMR_TAIL = 2'h1;
	// state lengths in clock cycles
	localparam int CNT_W = 13;
	localparam logic [12:0] CAL_SHORT_CYC = 13'h004C;
	localparam logic [12:0] ACQ12_BASE = 13'h0009;
	localparam logic [12:0] ACQ8_BASE = 13'h0002;
	localparam logic [12:0] CMP1_CYC = 13'h0005;
	localparam logic [12:0] LIM2_CYC = 13'h0001;
	localparam logic [12:0] CONV12_CYC = 13'h002C;
	localparam logic [12:0] CONV8_CYC = 13'h0015;
	localparam logic [12:0] CMP2_CYC = 13'h0005;
	localparam logic [12:0] ONE_CYC = 13'h0001;
	// fill of the four low result bits in 8-bit mode
	localparam logic [3:0] LOW_FILL8 = 4'hE;

	typedef enum logic [2:0] {
		ST_FETCH, ST_CHECK, ST_CAL, ST_TIMER,
		ST_ACQ, ST_CMP1, ST_LIM2, ST_CONV
	} adsq_state_t;

	// decoded fields of the current instruction word
	typedef struct packed {
		logic timerEn;
		logic pause;
		logic loop;
		logic watchdog;
		logic res8;
		logic [3:0] acqD;
	} adsq_instr_t;

	// configuration bits held outside this core
	typedef struct packed {
		logic start;
		logic reset;
		logic calShort;
		logic calLong;
		logic tagInstr;
	} adsq_cfg_t;

	// raw converter answer
	typedef struct packed {
		logic sign;
		logic [11:0] mag;
	} adsq_adc_t;
endpackage : adsq_pkg

// ### hdl/adsq_core.sv
// sequencer, wait timer, result fifo, limit flags and dma request
// Operation
// R01: limit bit n on first-limit crossing, bit 8+n on second.
// R02: limit flags clear when read or on device reset.
// R03: 16-bit wait timer behind 5-bit prescaler, 32-cycle steps.
// R04: timer preset read/write, low byte bits 0-7, high 8-15, auto reload.
// R05: timer only when instruction enables it; wait 32N+2 cycles.
// R06: count equals threshold with enable: request high, interrupt low.
// R07: request drops once the fifo is emptied.
// R08: fifo flag cleared by status read; no new request before.
// R09: 8-bit dma reads low then high at two fixed addresses.
// R10: 32-entry 16-bit read-only result fifo.
// R11: sign bit 12, upper magnitude 4-11, low 0-3 or 1110.
// R12: bits 13-15 hold sign copies or instruction address.
// R13: write into a full fifo drops the oldest result.
// R14: high byte read first pops the entry, losing low byte.
// R15: interrupts never stop the sequencer; pause, start, reset do.
// R16: with start cleared the current conversion finishes and stores.
// R17: 3-bit pointer, reset to zero, wraps, zero after loop.
// R18: pointer readable any time in status bits 8-10.
// R19: fetch one cycle; check one cycle or idles while stopped.
// R20: calibration 76 cycles short, 4944 cycles full.
// R21: acquisition 9+2D or 2+2D cycles, D from bits 12-15.
// R22: conversion 44, 21 or 5; first compare 5, limit read 1.
// R23: fifo interrupt when count equals threshold 1..31.
// R24: stored result count shown in status bits 11-15.
// R25: states run fetch to convert, skipping unrequested ones.
`timescale 1ns/10ps
module adsq_core #(
	parameter int CAL_LONG_CYC = 4944
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [4:0] busAddr,
	input wire logic busRd,
	input wire logic busWr,
	input wire logic [15:0] busWrData,
	input wire logic bus_width_select,
	output logic [15:0] busRdData,
	input wire adsq_pkg::adsq_cfg_t cfg,
	input wire logic fifoIntEn,
	input wire logic [4:0] fifoThreshold,
	input wire logic intStatusRd,
	input wire adsq_pkg::adsq_instr_t instr,
	input wire adsq_pkg::adsq_adc_t adcResult,
	input wire logic limit1Hit,
	input wire logic limit2Hit,
	output logic [2:0] sequence_position_counter,
	output logic [4:0] fifoCount,
	output logic fifoFlag,
	output logic transfer_request_out,
	output logic fifoInt_n,
	output logic seqRunning
);
	import adsq_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	if (CAL_LONG_CYC < 2 || CAL_LONG_CYC > 8191) begin : g_chk
		$error("CAL_LONG_CYC outside the state counter range");
	end
	localparam logic [12:0] CAL_LONG = CAL_LONG_CYC[12:0];

	// length of a counted state, minus one
	function automatic logic [12:0] stateLen(input adsq_state_t s,
		input adsq_instr_t ins, input adsq_cfg_t c);
		logic [12:0] len;
		logic [12:0] twoD;
		twoD = {8'h00, ins.acqD, 1'b0};
		len = ONE_CYC;
		case (s)
			ST_CAL: len = c.calLong ? CAL_LONG : CAL_SHORT_CYC; // see R20
			ST_ACQ: len = (ins.res8 || ins.watchdog) ? // see R21
				ACQ8_BASE + twoD : ACQ12_BASE + twoD;
			ST_CMP1: len = CMP1_CYC; // see R22
			ST_LIM2: len = LIM2_CYC;
			ST_CONV: len = ins.watchdog ? CMP2_CYC : // see R22
				ins.res8 ? CONV8_CYC : CONV12_CYC;
			default: len = ONE_CYC;
		endcase
		return len - ONE_CYC;
	endfunction : stateLen

	// ****************************************
	// register bus decode
	// ****************************************
	logic [3:0] regIdx;
	logic byteHi;
	logic lastByte;
	logic rdFifo;
	logic rdLimit;
	logic wrTimer;
	assign regIdx = busAddr[4:1];
	assign byteHi = busAddr[0];
	// in 8-bit mode only the high byte completes an access
	assign lastByte = !bus_width_select || byteHi;
	assign rdFifo = busRd && regIdx == REG_FIFO;
	assign rdLimit = busRd && regIdx == REG_LIMIT && lastByte;
	assign wrTimer = busWr && regIdx == REG_TIMER;

	// ****************************************
	// wait timer preset
	// ****************************************
	logic [15:0] preset_ff;
	logic [15:0] nxt_preset;
	always_comb begin // see R04
		nxt_preset = preset_ff;
		if (wrTimer && !bus_width_select) begin
			nxt_preset = busWrData;
		end else if (wrTimer && byteHi) begin
			nxt_preset[15:8] = busWrData[7:0];
		end else if (wrTimer) begin
			nxt_preset[7:0] = busWrData[7:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) preset_ff <= 16'h0000;
		else preset_ff <= nxt_preset;
	end

	// ****************************************
	// sequencer
	// ****************************************
	adsq_state_t st_ff, nxt_st;
	logic [12:0] cnt_ff, nxt_cnt;
	logic [15:0] tmr_ff, nxt_tmr;
	logic [4:0] pre_ff, nxt_pre;
	logic [1:0] tail_ff, nxt_tail;
	logic [2:0] ptr_ff, nxt_ptr;
	logic pauseHold_ff, nxt_pauseHold;
	logic stopped;
	logic wantCal;
	logic cntDone;
	logic tmrDone;
	logic convEnd;
	logic pushReq;
	logic pushReady;
	logic lim1Set;
	logic lim2Set;
	// a pause latches until start drops, so the pause does not retrigger
	assign stopped = cfg.reset || !cfg.start || pauseHold_ff || instr.pause;
	assign wantCal = cfg.calShort || cfg.calLong;
	assign cntDone = cnt_ff == 13'h0000;
	assign tmrDone = tmr_ff == 16'h0000 && tail_ff == 2'h0;
	assign convEnd = st_ff == ST_CONV && cntDone;
	assign pushReq = convEnd && !instr.watchdog;
	assign lim1Set = st_ff == ST_CMP1 && cntDone && limit1Hit;
	assign lim2Set = convEnd && instr.watchdog && limit2Hit;

	// next state; interrupts have no say here, see R15
	always_comb begin // see R25
		nxt_st = st_ff;
		case (st_ff)
			ST_FETCH: nxt_st = ST_CHECK; // see R19
			ST_CHECK: begin // see R19
				if (stopped) nxt_st = ST_CHECK;
				else if (wantCal) nxt_st = ST_CAL;
				else if (instr.timerEn) nxt_st = ST_TIMER; // see R05
				else nxt_st = ST_ACQ;
			end
			ST_CAL: begin
				if (cntDone && instr.timerEn) nxt_st = ST_TIMER;
				else if (cntDone) nxt_st = ST_ACQ;
			end
			ST_TIMER: if (tmrDone) nxt_st = ST_ACQ;
			ST_ACQ: begin
				if (cntDone && instr.watchdog) nxt_st = ST_CMP1;
				else if (cntDone) nxt_st = ST_CONV;
			end
			ST_CMP1: if (cntDone) nxt_st = ST_LIM2;
			ST_LIM2: if (cntDone) nxt_st = ST_CONV;
			// start is only looked at in check, so a conversion ends, see R16
			// a stalled result buffer holds the conversion end
			ST_CONV: if (cntDone && (!pushReq || pushReady)) nxt_st = ST_FETCH;
			default: nxt_st = ST_FETCH;
		endcase
		if (cfg.reset) nxt_st = ST_FETCH;
	end

	// state counter reloads on each change of state
	always_comb begin
		nxt_cnt = cnt_ff;
		if (nxt_st != st_ff) nxt_cnt = stateLen(nxt_st, instr, cfg);
		else if (!cntDone) nxt_cnt = cnt_ff - ONE_CYC;
	end

	// prescaled timer: 32 cycles per count, then the tail
	always_comb begin // see R03
		nxt_tmr = tmr_ff;
		nxt_pre = pre_ff;
		nxt_tail = tail_ff;
		if (st_ff != ST_TIMER) begin
			nxt_tmr = preset_ff; // see R04
			nxt_pre = PRE_MAX;
			nxt_tail = TMR_TAIL;
		end else if (tmr_ff != 16'h0000) begin // see R05
			nxt_pre = pre_ff - 5'h01;
			if (pre_ff == 5'h00) nxt_tmr = tmr_ff - 16'h0001;
		end else if (tail_ff != 2'h0) begin
			nxt_tail = tail_ff - 2'h1;
		end
	end

	// pointer steps at instruction end, zero after a loop
	always_comb begin // see R17
		nxt_ptr = ptr_ff;
		if (cfg.reset) nxt_ptr = 3'h0;
		else if (st_ff == ST_CONV && nxt_st == ST_FETCH && instr.loop) nxt_ptr = 3'h0;
		else if (st_ff == ST_CONV && nxt_st == ST_FETCH) nxt_ptr = ptr_ff + 3'h1;
		nxt_pauseHold = pauseHold_ff;
		if (cfg.reset || !cfg.start) nxt_pauseHold = 1'b0;
		else if (st_ff == ST_CHECK && instr.pause) nxt_pauseHold = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= ST_FETCH;
			cnt_ff <= 13'h0000;
			tmr_ff <= 16'h0000;
			pre_ff <= PRE_MAX;
			tail_ff <= TMR_TAIL;
			ptr_ff <= 3'h0;
			pauseHold_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			tmr_ff <= nxt_tmr;
			pre_ff <= nxt_pre;
			tail_ff <= nxt_tail;
			ptr_ff <= nxt_ptr;
			pauseHold_ff <= nxt_pauseHold;
		end
	end
	assign sequence_position_counter = ptr_ff; // see R18
	assign seqRunning = st_ff != ST_CHECK;

	// ****************************************
	// limit flags
	// ****************************************
	logic [15:0] limit_ff, nxt_limit, limSet;
	assign limSet = ({8'h00, 8'(lim1Set) << ptr_ff}) |
		({8'(lim2Set) << ptr_ff, 8'h00});
	// a crossing in the read cycle survives the clear
	always_comb begin // see R01
		nxt_limit = limit_ff;
		if (rdLimit || cfg.reset) nxt_limit = 16'h0000; // see R02
		nxt_limit = nxt_limit | limSet;
	end
	always_ff @(posedge core_clk) begin
		if (rst) limit_ff <= 16'h0000;
		else limit_ff <= nxt_limit;
	end

	// ****************************************
	// result formatting and two-entry buffer
	// ****************************************
	logic [15:0] resWord;
	logic [2:0] resTag;
	logic [3:0] resLow;
	logic [15:0] buf_ff [2];
	logic [1:0] bufCnt_ff, nxt_bufCnt;
	logic bufOut;
	logic popNow;
	assign resTag = cfg.tagInstr ? ptr_ff : {3{adcResult.sign}}; // see R12
	assign resLow = instr.res8 ? LOW_FILL8 : adcResult.mag[3:0];
	assign resWord = {resTag, adcResult.sign, adcResult.mag[11:4], resLow}; // see R11
	assign pushReady = bufCnt_ff != 2'h2;
	// fifo takes a word only in cycles without a host pop
	assign bufOut = bufCnt_ff != 2'h0 && !popNow;
	always_comb begin
		nxt_bufCnt = bufCnt_ff;
		if ((pushReq && pushReady) && !bufOut) nxt_bufCnt = bufCnt_ff + 2'h1;
		else if (!(pushReq && pushReady) && bufOut) nxt_bufCnt = bufCnt_ff - 2'h1;
	end
	always_ff @(posedge core_clk) begin
		if (rst || cfg.reset) bufCnt_ff <= 2'h0;
		else bufCnt_ff <= nxt_bufCnt;
	end
	always_ff @(posedge core_clk) begin
		if (bufOut) buf_ff[0] <= buf_ff[1];
		if (pushReq && pushReady) begin
			buf_ff[(bufOut ? 2'h1 : 2'h0) == 2'h0 ? bufCnt_ff[0]
				: bufCnt_ff[0] ^ 1'b1] <= resWord;
		end
	end

	// ****************************************
	// result fifo
	// ****************************************
	logic [15:0] fifo_ff [32];
	logic [4:0] wrPtr_ff, rdPtr_ff;
	logic [5:0] count_ff, nxt_count;
	logic fifoFull;
	assign fifoFull = count_ff == FIFO_FULL;
	// empty reads are ignored; high byte read pops, see R14
	assign popNow = rdFifo && lastByte && count_ff != 6'h00;
	always_comb begin // see R13
		nxt_count = count_ff;
		if (bufOut && !fifoFull) nxt_count = count_ff + 6'h01;
		else if (popNow) nxt_count = count_ff - 6'h01;
	end
	always_ff @(posedge core_clk) begin // see R10
		if (rst || cfg.reset) begin
			wrPtr_ff <= 5'h00;
			rdPtr_ff <= 5'h00;
			count_ff <= 6'h00;
		end else begin
			count_ff <= nxt_count;
			if (bufOut) wrPtr_ff <= wrPtr_ff + 5'h01;
			if (popNow || (bufOut && fifoFull)) rdPtr_ff <= rdPtr_ff + 5'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (bufOut) fifo_ff[wrPtr_ff] <= buf_ff[0];
	end
	assign fifoCount = count_ff[4:0]; // see R24

	// ****************************************
	// fifo flag, dma request, interrupt pin
	// ****************************************
	logic flag_ff, nxt_flag, dma_ff, nxt_dma, intN_ff;
	logic hitThr;
	// a device reset empties the fifo, so no threshold hit in that cycle
	assign hitThr = bufOut && !cfg.reset && fifoThreshold != 5'h00 &&
		nxt_count == {1'b0, fifoThreshold}; // see R23
	always_comb begin // see R08
		nxt_flag = flag_ff;
		if (intStatusRd || cfg.reset) nxt_flag = 1'b0;
		if (hitThr) nxt_flag = 1'b1;
		nxt_dma = dma_ff;
		if (nxt_count == 6'h00 || cfg.reset) nxt_dma = 1'b0; // see R07
		if (hitThr && fifoIntEn && !flag_ff) nxt_dma = 1'b1; // see R06
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flag_ff <= 1'b0;
			dma_ff <= 1'b0;
			intN_ff <= 1'b1;
		end else begin
			flag_ff <= nxt_flag;
			dma_ff <= nxt_dma;
			intN_ff <= !(nxt_flag && fifoIntEn); // see R06
		end
	end
	assign fifoFlag = flag_ff;
	assign transfer_request_out = dma_ff;
	assign fifoInt_n = intN_ff;

	// ****************************************
	// read data
	// ****************************************
	logic [15:0] rdWord, rdSel, rdData_ff;
	assign rdWord = regIdx == REG_TIMER ? preset_ff :
		regIdx == REG_FIFO ? fifo_ff[rdPtr_ff] :
		regIdx == REG_LIMIT ? limit_ff : 16'h0000;
	assign rdSel = !bus_width_select ? rdWord :
		byteHi ? {8'h00, rdWord[15:8]} : {8'h00, rdWord[7:0]};
	always_ff @(posedge core_clk) begin
		if (rst) rdData_ff <= 16'h0000;
		else if (busRd) rdData_ff <= rdSel;
	end
	assign busRdData = rdData_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [21:0] tmrSpan_ff;
	always_ff @(posedge core_clk) begin
		if (rst || st_ff != ST_TIMER) tmrSpan_ff <= 22'h000000;
		else tmrSpan_ff <= tmrSpan_ff + 22'h000001;
	end

	limit_read_clear_a: assert property ( // see R02
		rdLimit && limSet == 16'h0000 |=> limit_ff == 16'h0000)
		else $error("limit flags not cleared by read");
	limit_first_set_a: assert property ( // see R01
		lim1Set |=> limit_ff[$past(ptr_ff)])
		else $error("first limit flag not set");
	timer_span_a: assert property ( // see R05
		st_ff == ST_TIMER && nxt_st != ST_TIMER && !cfg.reset |->
		tmrSpan_ff + 22'h000001 == {1'b0, preset_ff, 5'h00} + 22'h000002)
		else $error("timer wait length wrong");
	fetch_one_cycle_a: assert property ( // see R19
		st_ff == ST_FETCH && !cfg.reset |=> st_ff == ST_CHECK)
		else $error("fetch not one cycle");
	ptr_loop_a: assert property ( // see R17
		st_ff == ST_CONV && nxt_st == ST_FETCH && instr.loop |=> ptr_ff == 3'h0)
		else $error("pointer not zero after loop");
	dma_empty_a: assert property ( // see R07
		count_ff == 6'h00 |-> !dma_ff)
		else $error("dma request with empty fifo");
	dma_int_pair_a: assert property ( // see R06
		$rose(dma_ff) |-> !intN_ff && flag_ff)
		else $error("dma rose without interrupt");
	dma_after_clear_a: assert property ( // see R08
		$rose(dma_ff) |-> !$past(flag_ff))
		else $error("dma request before flag clear");
	fifo_full_keep_a: assert property ( // see R13
		fifoFull && bufOut && !cfg.reset |=> fifoFull)
		else $error("full fifo lost depth");
endmodule : adsq_core

// ### sim/adsq_dma_model.sv
// dma controller model that unloads the result fifo on request
`timescale 1ns/10ps
module adsq_dma_model (
	input wire logic core_clk,
	input wire logic enable,
	input wire logic transfer_request_out,
	input wire logic [15:0] busRdData,
	output logic rdStrobe,
	output logic gotWord,
	output logic [15:0] word
);
	// one read at the fixed fifo address, then an idle gap of two or three
	// cycles so a request that falls late never reads an empty fifo
	initial begin
		rdStrobe = 1'b0;
		gotWord = 1'b0;
		word = 16'h0000;
		forever begin
			@(negedge core_clk);
			if (enable && transfer_request_out === 1'b1) begin
				rdStrobe = 1'b1;
				@(negedge core_clk);
				rdStrobe = 1'b0;
				word = busRdData;
				gotWord = 1'b1;
				@(negedge core_clk);
				gotWord = 1'b0;
				repeat ($urandom_range(1)) @(negedge core_clk);
			end
		end
	end
endmodule : adsq_dma_model

// ### sim/adsq_core_test.sv
// self-checking bench for the acquisition sequencer core
`timescale 1ns/10ps
module adsq_core_test;
	import adsq_pkg::*;
	localparam int CALL = 20;
	localparam int LIMIT_NS = 200000;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] tAddr = 5'h00;
	logic tRd = 1'b0;
	logic busWr = 1'b0;
	logic [15:0] busWrData = 16'h0000;
	logic bus_width_select = 1'b0;
	adsq_cfg_t cfg = '0;
	logic fifoIntEn = 1'b0;
	logic [4:0] fifoThreshold = 5'h01;
	logic intStatusRd = 1'b0;
	adsq_instr_t instr = '0;
	adsq_adc_t adcResult = '0;
	logic limit1Hit = 1'b0;
	logic limit2Hit = 1'b0;
	logic dmaOn = 1'b0;
	logic mRd;
	logic gotWord;
	logic [15:0] word;
	logic [15:0] busRdData;
	logic [2:0] ptr;
	logic [4:0] fifoCount;
	logic fifoFlag;
	logic req;
	logic reqWas = 1'b0;
	logic fifoInt_n;
	logic seqRunning;
	logic [15:0] q[$];
	logic [15:0] limExp = 16'h0000;
	logic [15:0] preset = 16'h0000;
	logic [15:0] d;
	logic [15:0] v;
	bit timed = 1'b0;
	int rises = 0;
	// cycles of the current instruction already spent before run starts
	int skew = 0;
	int badCount = 0;
	int checksDone = 0;
	// the dma model owns the read strobe while it is enabled
	wire logic busRd = dmaOn ? mRd : tRd;
	wire logic [4:0] busAddr = dmaOn ? {REG_FIFO, 1'b0} : tAddr;

	always #2 core_clk = ~core_clk;

	adsq_core #(.CAL_LONG_CYC(CALL)) u_adsq_core (
		.core_clk(core_clk),
		.rst(rst),
		.busAddr(busAddr),
		.busRd(busRd),
		.busWr(busWr),
		.busWrData(busWrData),
		.bus_width_select(bus_width_select),
		.busRdData(busRdData),
		.cfg(cfg),
		.fifoIntEn(fifoIntEn),
		.fifoThreshold(fifoThreshold),
		.intStatusRd(intStatusRd),
		.instr(instr),
		.adcResult(adcResult),
		.limit1Hit(limit1Hit),
		.limit2Hit(limit2Hit),
		.sequence_position_counter(ptr),
		.fifoCount(fifoCount),
		.fifoFlag(fifoFlag),
		.transfer_request_out(req),
		.fifoInt_n(fifoInt_n),
		.seqRunning(seqRunning)
	);

	adsq_dma_model u_adsq_dma_model (
		.core_clk(core_clk),
		.enable(dmaOn),
		.transfer_request_out(req),
		.busRdData(busRdData),
		.rdStrobe(mRd),
		.gotWord(gotWord),
		.word(word)
	);

	// ****************************************
	// checks and bus tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// strobes drop for a cycle so two calls never collide in one step
	task automatic wr(input logic [4:0] a, input logic [15:0] x);
		tAddr = a;
		busWrData = x;
		busWr = 1'b1;
		@(negedge core_clk);
		busWr = 1'b0;
		@(negedge core_clk);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] x);
		tAddr = a;
		tRd = 1'b1;
		@(negedge core_clk);
		tRd = 1'b0;
		@(negedge core_clk);
		x = busRdData;
	endtask : rd

	function automatic logic [15:0] expWord(adsq_instr_t i, adsq_adc_t r,
		logic tag, logic [2:0] p);
		logic [3:0] lo;
		lo = i.res8 ? LOW_FILL8 : r.mag[3:0];
		return {tag ? p : {3{r.sign}}, r.sign, r.mag[11:4], lo};
	endfunction : expWord

	// cycles from one pointer step to the next
	function automatic int expCyc(adsq_instr_t i, int cal, int n);
		int c;
		c = 2 + cal + (i.timerEn ? 32 * n + 2 : 0);
		if (i.watchdog)
			c += 2 + 2 * i.acqD + 11;
		else if (i.res8)
			c += 2 + 2 * i.acqD + 21;
		else
			c += 9 + 2 * i.acqD + 44;
		return c;
	endfunction : expCyc

	task automatic newInstr(input bit wdOk);
		instr = adsq_instr_t'(9'($urandom));
		instr.pause = 1'b0;
		instr.watchdog = instr.watchdog & wdOk;
		instr.loop = ($urandom_range(15) == 0);
		adcResult = adsq_adc_t'(13'($urandom));
		{limit1Hit, limit2Hit} = 2'($urandom);
		cfg.calShort = ($urandom_range(5) == 0);
		cfg.calLong = ($urandom_range(7) == 0);
		cfg.tagInstr = 1'($urandom);
	endtask : newInstr

	// runs n instructions, timing each one whose predecessor ran with start set, and recording what it stores
	task automatic run(input int n, input bit wdOk);
		int cyc;
		int cal;
		logic [2:0] p;
		for (int k = 0; k < n; k++) begin
			p = ptr;
			cal = cfg.calLong ? CALL : cfg.calShort ? 76 : 0;
			cyc = skew;
			skew = 0;
			while (ptr === p && cyc < 40000) begin
				@(negedge core_clk);
				cyc++;
			end
			if (timed)
				check("period", 16'(cyc), 16'(expCyc(instr, cal, preset)));
			check("pointer", ptr, instr.loop ? 3'h0 : 3'(p + 3'h1));
			if (instr.watchdog)
				limExp = limExp | (16'(limit1Hit) << p) | (16'(limit2Hit) << (8 + p));
			else
				q.push_back(expWord(instr, adcResult, cfg.tagInstr, p));
			if (q.size() > 32)
				void'(q.pop_front());
			timed = cfg.start;
			newInstr(wdOk);
		end
	endtask : run

	// clearing start mid-instruction still completes and stores it
	task automatic halt();
		logic [2:0] p;
		repeat (4) @(negedge core_clk);
		skew = 4;
		cfg.start = 1'b0;
		run(1, 1'b1);
		p = ptr;
		repeat (60) @(negedge core_clk);
		check("halted pointer", ptr, p);
		check("halted state", seqRunning, 1'b0);
		check("count", fifoCount, 5'(q.size()));
	endtask : halt

	task automatic drain16(input int n);
		repeat (n) begin
			rd({REG_FIFO, 1'b0}, d);
			check("fifo word", d, q.pop_front());
		end
	endtask : drain16

	task automatic byteRead(input bit hiFirst);
		logic [15:0] w;
		w = q.pop_front();
		if (!hiFirst) begin
			rd({REG_FIFO, 1'b0}, d);
			check("low byte", d, {8'h00, w[7:0]});
		end
		rd({REG_FIFO, 1'b1}, d);
		check("high byte", d, {8'h00, w[15:8]});
	endtask : byteRead

	task automatic pulseStatusRead();
		intStatusRd = 1'b1;
		@(negedge core_clk);
		intStatusRd = 1'b0;
		@(negedge core_clk);
		check("flag clear", fifoFlag, 1'b0);
	endtask : pulseStatusRead

	task automatic finalReport();
		if (badCount == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finalReport

	// words taken by the dma model come out in stored order
	always @(posedge core_clk) begin
		if (gotWord)
			check("dma word", word, q.pop_front());
	end

	// request edges: count at threshold on the rise, fifo empty on the fall
	always @(negedge core_clk) begin
		if (req === 1'b1 && reqWas !== 1'b1) begin
			rises++;
			check("count at request", fifoCount, fifoThreshold);
			check("int at request", fifoInt_n, 1'b0);
		end
		if (req === 1'b0 && reqWas === 1'b1)
			check("count at release", fifoCount, 5'h00);
		reqWas = req;
	end

	initial begin
		#LIMIT_NS;
		badCount++;
		finalReport();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(89344));
		newInstr(1'b1);
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		check("reset pointer", ptr, 3'h0);
		check("reset request", {req, fifoInt_n, fifoCount}, 7'h20);
		v = 16'($urandom);
		wr({REG_TIMER, 1'b0}, v);
		rd({REG_TIMER, 1'b0}, d);
		check("timer word", d, v);
		bus_width_select = 1'b1;
		wr({REG_TIMER, 1'b1}, {8'h00, v[7:0]});
		rd({REG_TIMER, 1'b1}, d);
		check("timer high", d, {8'h00, v[7:0]});
		rd({REG_TIMER, 1'b0}, d);
		check("timer low", d, {8'h00, v[7:0]});
		bus_width_select = 1'b0;
		rd({4'h3, 1'b0}, d);
		check("unmapped", d, 16'h0000);
		preset = 16'($urandom_range(3));
		wr({REG_TIMER, 1'b0}, preset);
		cfg.start = 1'b1;
		run(20, 1'b1);
		halt();
		wr({REG_LIMIT, 1'b0}, 16'hFFFF);
		rd({REG_LIMIT, 1'b0}, d);
		check("limit flags", d, limExp);
		rd({REG_LIMIT, 1'b0}, d);
		check("limit cleared", d, 16'h0000);
		limExp = 16'h0000;
		drain16(q.size());
		// a paused instruction holds the sequencer in its rest state
		v = 16'(ptr);
		instr.pause = 1'b1;
		cfg.start = 1'b1;
		repeat (100) @(negedge core_clk);
		check("pause", {ptr, seqRunning}, {v[2:0], 1'b0});
		cfg.start = 1'b0;
		@(negedge core_clk);
		instr.pause = 1'b0;
		cfg.start = 1'b1;
		run(34, 1'b0);
		halt();
		bus_width_select = 1'b1;
		byteRead(1'b0);
		byteRead(1'b1);
		byteRead(1'b0);
		bus_width_select = 1'b0;
		drain16(q.size());
		pulseStatusRead();
		check("no request", 16'(rises), 16'h0000);
		fifoThreshold = 5'($urandom_range(5, 2));
		fifoIntEn = 1'b1;
		dmaOn = 1'b1;
		cfg.start = 1'b1;
		run(2 * fifoThreshold + 1, 1'b0);
		check("one request", 16'(rises), 16'h0001);
		halt();
		dmaOn = 1'b0;
		pulseStatusRead();
		check("int released", fifoInt_n, 1'b1);
		drain16(q.size());
		dmaOn = 1'b1;
		cfg.start = 1'b1;
		run(fifoThreshold + 1, 1'b0);
		halt();
		check("second request", 16'(rises), 16'h0002);
		dmaOn = 1'b0;
		// device reset clears pointer, fifo and flags, not the preset
		cfg.reset = 1'b1;
		repeat (2) @(negedge core_clk);
		cfg.reset = 1'b0;
		@(negedge core_clk);
		check("cleared", {ptr, fifoCount, fifoFlag}, 9'h000);
		rd({REG_LIMIT, 1'b0}, d);
		check("limit after reset", d, 16'h0000);
		rd({REG_TIMER, 1'b0}, d);
		check("preset kept", d, preset);
		finalReport();
	end
endmodule : adsq_core_test
